// File: design/lamp_pkg.sv
// Purpose: Constants for the status lamp and node condition block
// Assumes: 100 MHz system clock
// Notes:   Blink periods are derived from the clock rate below
package lamp_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;

  localparam int unsigned BLINK_SLOW_HZ = 1;
  localparam int unsigned BLINK_MID_HZ  = 2;
  localparam int unsigned BLINK_FAST_HZ = 10;

  // Half periods in cycles, for a 50 percent duty square wave
  localparam int unsigned HALF_SLOW = CLK_HZ / (2 * BLINK_SLOW_HZ);
  localparam int unsigned HALF_MID  = CLK_HZ / (2 * BLINK_MID_HZ);
  localparam int unsigned HALF_FAST = CLK_HZ / (2 * BLINK_FAST_HZ);

  // Width of one node's condition code
  localparam int unsigned CODE_W = 8;

  typedef enum logic [2:0] {
    SM_INIT,
    SM_PREOP,
    SM_BOOTSTRAP,
    SM_SAFEOP,
    SM_OP
  } slave_state_t;

  localparam logic [7:0] NODE_NO_ERROR      = 8'h00;
  localparam logic [7:0] NODE_DEACTIVATED   = 8'h01;
  localparam logic [7:0] NODE_ABSENT        = 8'h02;
  localparam logic [7:0] NODE_MASTER_LOCK   = 8'h03;
  localparam logic [7:0] NODE_BAD_RESPONSE  = 8'h04;
  localparam logic [7:0] NODE_PARAM_FAULT   = 8'h05;
  localparam logic [7:0] NODE_UNSUPPORTED   = 8'h06;
  localparam logic [7:0] NODE_CONFIG_FAULT  = 8'h07;
  localparam logic [7:0] NODE_NOT_READY     = 8'h08;
  localparam logic [7:0] NODE_STATIC_DIAG   = 8'h09;
  localparam logic [7:0] NODE_DIAG_OVERFLOW = 8'h0A;
  localparam logic [7:0] NODE_PHYS_FAULT    = 8'h0B;

endpackage

// File: design/status_lamp_and_node_state.sv
// Purpose: Drives run, fault and processor lamps; publishes node condition codes
// Assumes: All inputs come from logic on clk_sys; HALF_* may be shortened for simulation
// Notes:   Codes above the documented range are passed through unchanged
module status_lamp_and_node_state #(
  parameter int unsigned NODES     = 4,
  parameter int unsigned HALF_SLOW = lamp_pkg::HALF_SLOW,
  parameter int unsigned HALF_MID  = lamp_pkg::HALF_MID,
  parameter int unsigned HALF_FAST = lamp_pkg::HALF_FAST
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  lamp_pkg::slave_state_t     slave_state,
  input  wire logic [NODES*8-1:0]    node_code_in,
  input  wire logic [NODES-1:0]      node_configured,
  input  wire logic                  task_running,
  input  wire logic                  config_upload,
  input  wire logic                  can_bus_off,
  input  wire logic                  restart,
  input  wire logic                  cpu_starting,
  input  wire logic                  cpu_error,
  output logic                       lamp_run,
  output logic                       lamp_err,
  output logic                       lamp_cpu,
  output logic                       outputs_safe,
  output logic [NODES*8-1:0]         per_node_condition_code,
  output logic                       diagnosis_pending_flag
);

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int unsigned CODE_W   = lamp_pkg::CODE_W;
  localparam int unsigned DIVS     = 3;
  localparam int unsigned DIV_SLOW = 0;
  localparam int unsigned DIV_MID  = 1;
  localparam int unsigned DIV_FAST = 2;

  // Counters are sized by the longest half period, whichever rate that is
  localparam int unsigned HALF_MAX =
    (HALF_SLOW >= HALF_MID && HALF_SLOW >= HALF_FAST) ? HALF_SLOW :
    (HALF_MID >= HALF_FAST)                           ? HALF_MID  : HALF_FAST;
  localparam int unsigned CW       = $clog2(HALF_MAX + 1);

  // ------------------------------------------------------------------
  // Blink dividers
  // ------------------------------------------------------------------
  logic [DIVS-1:0] wave;
  logic            blink_1hz;
  logic            blink_2hz;
  logic            blink_10hz;

  for (genvar g = 0; g < DIVS; g++) begin : g_div
    localparam int unsigned HALF = (g == DIV_SLOW) ? HALF_SLOW :
                                   (g == DIV_MID)  ? HALF_MID  : HALF_FAST;
    // Wrapping at HALF-1 and toggling keeps the lit and dark spans equal
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    logic [CW-1:0] div_r;
    logic [CW-1:0] div_nxt;
    logic          wave_r;
    logic          wave_nxt;

    always_comb begin
      div_nxt  = div_r + CW'(1);
      wave_nxt = wave_r;
      // Greater-or-equal, so a corrupted count cannot run the long way round
      if (div_r >= LAST) begin
        div_nxt  = '0;
        wave_nxt = ~wave_r;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        div_r  <= '0;
        wave_r <= 1'b0;
      end else begin
        div_r  <= div_nxt;
        wave_r <= wave_nxt;
      end
    end

    assign wave[g] = wave_r;
  end

  // All lamps share the dividers, so lamps on one rate blink in phase
  assign blink_1hz  = wave[DIV_SLOW];
  assign blink_2hz  = wave[DIV_MID];
  assign blink_10hz = wave[DIV_FAST];

  // ------------------------------------------------------------------
  // Node codes and fault summary
  // ------------------------------------------------------------------
  // zero means no error
  function automatic logic code_is_fault(input logic [CODE_W-1:0] code);
    return code != lamp_pkg::NODE_NO_ERROR;
  endfunction

  logic [NODES-1:0]        node_fault;
  logic                    any_fault;
  logic [NODES*CODE_W-1:0] code_r;
  logic [NODES*CODE_W-1:0] code_nxt;
  logic                    busoff_r;
  logic                    busoff_nxt;

  // Unconfigured nodes may report anything without lighting the fault lamp
  for (genvar n = 0; n < NODES; n++) begin : g_node
    assign node_fault[n] = node_configured[n] & code_is_fault(node_code_in[n*CODE_W +: CODE_W]);
  end

  assign any_fault = |node_fault;

  always_comb begin
    code_nxt   = node_code_in;
    // Bus-off latches and set wins, so a brief bus-off pulse is still shown
    // hold until restart
    busoff_nxt = can_bus_off | (busoff_r & ~restart);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      code_r   <= '0;
      busoff_r <= 1'b0;
    end else begin
      code_r   <= code_nxt;
      busoff_r <= busoff_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Run lamp and safe outputs
  // ------------------------------------------------------------------
  logic run_r;
  logic run_nxt;
  logic safe_r;
  logic safe_nxt;

  always_comb begin
    safe_nxt = 1'b0;
    unique case (slave_state)
      lamp_pkg::SM_INIT,
      lamp_pkg::SM_BOOTSTRAP: run_nxt = 1'b0;
      lamp_pkg::SM_PREOP:     run_nxt = blink_2hz;
      lamp_pkg::SM_SAFEOP: begin
        run_nxt  = blink_1hz;
        safe_nxt = 1'b1;
      end
      lamp_pkg::SM_OP:        run_nxt = 1'b1;
      default:                run_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_r  <= 1'b0;
      safe_r <= 1'b0;
    end else begin
      run_r  <= run_nxt;
      safe_r <= safe_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Fault lamp
  // ------------------------------------------------------------------
  logic err_r;
  logic err_nxt;

  // Bus-off reaches the lamp through its latch, one cycle later than the rest
  always_comb begin
    if (busoff_r) begin
      err_nxt = 1'b1;
    end else if (config_upload) begin
      err_nxt = blink_10hz;
    end else if (any_fault) begin
      err_nxt = blink_1hz;
    end else begin
      // dark when all clear; a stopped task shows as a slow blink
      err_nxt = task_running ? 1'b0 : blink_1hz;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      err_r <= 1'b0;
    end else begin
      err_r <= err_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Processor lamp and diagnosis flag
  // ------------------------------------------------------------------
  logic cpu_r;
  logic cpu_nxt;
  logic diag_r;
  logic diag_nxt;

  always_comb begin
    if (cpu_error) begin
      cpu_nxt = 1'b1;
    end else if (cpu_starting) begin
      cpu_nxt = blink_10hz;
    end else begin
      cpu_nxt = 1'b0;
    end
    diag_nxt = any_fault;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cpu_r  <= 1'b0;
      diag_r <= 1'b0;
    end else begin
      cpu_r  <= cpu_nxt;
      diag_r <= diag_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign lamp_run                = run_r;
  assign lamp_err                = err_r;
  assign lamp_cpu                = cpu_r;
  assign outputs_safe            = safe_r;
  assign per_node_condition_code = code_r;
  assign diagnosis_pending_flag  = diag_r;

endmodule

// File: test/lamp_properties.sv
// Purpose: Port-level properties of the lamp block
// Assumes: Outputs follow inputs one clock later; lamp_err follows can_bus_off two clocks later
// Notes:   The bus-off latch is internal, so it is seen through lamp_err
module lamp_checker #(
  parameter int unsigned NODES = 4
) (
  input wire logic               clk_sys,
  input wire logic               rst,
  input lamp_pkg::slave_state_t  slave_state,
  input wire logic [NODES*8-1:0] node_code_in,
  input wire logic               can_bus_off,
  input wire logic               restart,
  input wire logic               cpu_error,
  input wire logic               lamp_run,
  input wire logic               lamp_err,
  input wire logic               lamp_cpu,
  input wire logic               outputs_safe,
  input wire logic [NODES*8-1:0] per_node_condition_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_off_held;
    can_bus_off ##1 !restart [*3];
  endsequence
  AST_RUN_DARK: assert property (slave_state inside {lamp_pkg::SM_INIT,
    lamp_pkg::SM_BOOTSTRAP} |=> !lamp_run) else $error("run lamp lit");
  AST_RUN_OP: assert property (slave_state == lamp_pkg::SM_OP |=> lamp_run)
    else $error("run lamp dark in op");
  AST_SAFE_ON: assert property (slave_state == lamp_pkg::SM_SAFEOP |=> outputs_safe)
    else $error("outputs not safe");
  AST_SAFE_OFF: assert property (slave_state != lamp_pkg::SM_SAFEOP |=> !outputs_safe)
    else $error("outputs safe outside safeop");
  // The bus-off latch adds one cycle ahead of the lamp register
  AST_BUS_OFF: assert property (can_bus_off |-> ##2 lamp_err)
    else $error("fault lamp dark on bus off");
  AST_BUS_OFF_HELD: assert property (s_off_held |=> lamp_err)
    else $error("bus off lamp dropped early");
  AST_CPU_ERR: assert property (cpu_error |=> lamp_cpu)
    else $error("cpu lamp dark on error");
  AST_CODE: assert property (1'b1 |=> per_node_condition_code == $past(node_code_in))
    else $error("node code not passed");
endmodule

bind status_lamp_and_node_state lamp_checker #(.NODES(NODES)) chk (
  .clk_sys                 (clk_sys),
  .rst                     (rst),
  .slave_state             (slave_state),
  .node_code_in            (node_code_in),
  .can_bus_off             (can_bus_off),
  .restart                 (restart),
  .cpu_error               (cpu_error),
  .lamp_run                (lamp_run),
  .lamp_err                (lamp_err),
  .lamp_cpu                (lamp_cpu),
  .outputs_safe            (outputs_safe),
  .per_node_condition_code (per_node_condition_code)
);

// File: test/lamp_watch.sv
// Purpose: Operator model that times how long a lamp holds each level
// Assumes: Lamp sampled on clk_sys
// Notes:   half is only valid after the lamp has changed twice; a steady lamp reads zero
module lamp_watch (
  input  wire logic       clk_sys,
  input  wire logic       lamp,
  output logic      [7:0] half
);
  timeunit 1ns;
  timeprecision 1ps;
  // Steady this long means not blinking at any bench rate, so no stale half survives
  localparam logic [7:0] STALE = 8'h20;
  logic [7:0] cnt_r = 8'h00;
  logic last_r = 1'b0;
  always @(posedge clk_sys) begin
    last_r <= lamp;
    cnt_r <= (lamp !== last_r) ? 8'h00 : cnt_r + 8'h01;
    if (lamp !== last_r) half <= cnt_r + 8'h01;
    else if (cnt_r == STALE) half <= 8'h00;
  end
endmodule

// File: test/test_status_lamp_and_node_state.sv
// Purpose: Self-checking bench for the lamp block
// Assumes: Blink half periods shortened to 20, 10 and 2 cycles
// Notes:   Blink rates are judged through the lamp_watch models
module test_status_lamp_and_node_state;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HS = 20;
  localparam int unsigned HM = 10;
  localparam int unsigned HF = 2;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  lamp_pkg::slave_state_t slave_state = lamp_pkg::SM_INIT;
  logic [31:0] node_code_in = 32'h0, per_node_condition_code;
  logic [3:0] node_configured = 4'hF;
  logic task_running = 1'b1, config_upload = 1'b0, can_bus_off = 1'b0, restart = 1'b0;
  logic cpu_starting = 1'b0, cpu_error = 1'b0;
  logic lamp_run, lamp_err, lamp_cpu, outputs_safe, diagnosis_pending_flag;
  logic [7:0] half_run, half_err, half_cpu;
  int errors = 0;
  int num_checks = 0;
  status_lamp_and_node_state #(.NODES(4), .HALF_SLOW(HS), .HALF_MID(HM), .HALF_FAST(HF)) uut (
    .clk_sys, .rst, .slave_state, .node_code_in, .node_configured, .task_running,
    .config_upload, .can_bus_off, .restart, .cpu_starting, .cpu_error, .lamp_run,
    .lamp_err, .lamp_cpu, .outputs_safe, .per_node_condition_code, .diagnosis_pending_flag);
  lamp_watch w_run (.clk_sys, .lamp(lamp_run), .half(half_run));
  lamp_watch w_err (.clk_sys, .lamp(lamp_err), .half(half_err));
  lamp_watch w_cpu (.clk_sys, .lamp(lamp_cpu), .half(half_cpu));
  initial forever #5 clk_sys = ~clk_sys;
  // Sample one step after the edge so the design's updates have landed
  task automatic settle(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic check(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_run_lamp();
    @(posedge clk_sys) slave_state <= lamp_pkg::SM_BOOTSTRAP;
    settle(60);
    check(lamp_run, 0);
    @(posedge clk_sys) slave_state <= lamp_pkg::SM_PREOP;
    settle(60);
    check(half_run, HM);
    @(posedge clk_sys) slave_state <= lamp_pkg::SM_SAFEOP;
    settle(60);
    check(half_run, HS);
    check(outputs_safe, 1);
    @(posedge clk_sys) slave_state <= lamp_pkg::SM_OP;
    settle(1);
    check(lamp_run, 1);
    check(outputs_safe, 0);
  endtask
  task automatic t_err_lamp();
    check(lamp_err, 0);
    for (int c = 0; c < 12; c++) begin
      @(posedge clk_sys) node_code_in <= {4{8'(c)}};
      settle(1);
      check(per_node_condition_code, {4{8'(c)}});
      check(diagnosis_pending_flag, c != 0);
    end
    // Fault on a node left out of the summary must not count
    @(posedge clk_sys);
    node_code_in <= 32'h0005_0000;
    node_configured <= 4'hB;
    settle(3);
    check(lamp_err, 0);
    // A stopped task with no configured node in fault is not the dark state
    @(posedge clk_sys) task_running <= 1'b0;
    settle(60);
    check(half_err, HS);
    @(posedge clk_sys) begin
      task_running    <= 1'b1;
      node_configured <= 4'hF;
    end
    settle(60);
    check(half_err, HS);
    @(posedge clk_sys) config_upload <= 1'b1;
    settle(20);
    check(half_err, HF);
    // Bus-off passes its latch before the lamp register
    @(posedge clk_sys) can_bus_off <= 1'b1;
    settle(2);
    check(lamp_err, 1);
    @(posedge clk_sys) can_bus_off <= 1'b0;
    settle(10);
    check(lamp_err, 1);
    @(posedge clk_sys) restart <= 1'b1;
    @(posedge clk_sys) restart <= 1'b0;
    settle(20);
    check(half_err, HF);
  endtask
  task automatic t_cpu_lamp();
    @(posedge clk_sys) cpu_starting <= 1'b1;
    settle(20);
    check(half_cpu, HF);
    @(posedge clk_sys) cpu_error <= 1'b1;
    settle(5);
    check(lamp_cpu, 1);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_run_lamp();
    t_err_lamp();
    t_cpu_lamp();
    tally_and_finish();
  end
  initial begin
    #20000;
    errors++;
    tally_and_finish();
  end
endmodule
